// file: rtl/mpsc_top.v
/*
 Module power-state controller: sequences S0/S3/S4/S5 from buttons, wake and
 thermal events, drives the suspend and thermal-trip outputs, and keeps a small
 register file with sticky event status, mask and one interrupt.
 Assumes one free-running standby clock and synchronous register strobes.
*/
// The register offsets and strobed register access are this design's own decisions.
`include "mpsc_map.vh"

module mpsc_top #(
	parameter CNT_W = `MPSC_CNT_W,
	parameter [CNT_W-1:0] PRESS_CYC = `MPSC_PRESS_CYC,
	parameter [7:0] NOTICE_CYC = `MPSC_NOTICE_CYC
) (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Carrier inputs
	input wire carrier_power_good,
	input wire power_button_n,
	input wire reset_button_n,
	input wire battery_low_n,
	input wire wake_n,
	input wire sleep_button_n,
	input wire lid_switch_n,
	input wire thermal_alarm_n,
	// Processor overheat indication
	input wire cpu_overheat,
	// Carrier outputs
	output reg suspend_status_n,
	output reg suspend_to_ram_n,
	output reg soft_off_state_n,
	output reg thermal_trip_n,
	output reg module_reset_n,
	// Register port
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	output reg irq
);
	localparam NIN = 7;

	wire [NIN-1:0] pins_s;
	wire pwr_s = pins_s[0];
	wire rstb_s = pins_s[1];
	wire bat_s = pins_s[2];
	wire wake_s = pins_s[3];
	wire slp_s = pins_s[4];
	wire lid_s = pins_s[5];
	wire therm_s = pins_s[6];
	wire [3:0] press;

	reg pg_meta_ff;
	reg pg_ff;
	reg heat_meta_ff;
	reg heat_ff;
	reg bat_d_ff;
	reg wake_d_ff;
	reg therm_d_ff;
	reg [`MPSC_ST_W-1:0] state_ff;
	reg [`MPSC_ST_W-1:0] nxt_state;
	reg [`MPSC_ST_W-1:0] target_ff;
	reg [`MPSC_ST_W-1:0] nxt_target;
	reg [7:0] note_cnt_ff;
	reg [`MPSC_EV_W-1:0] status_ff;
	reg [`MPSC_EV_W-1:0] mask_ff;
	reg [`MPSC_CTL_W-1:0] ctrl_ff;
	reg [`MPSC_EV_W-1:0] ev;
	reg trip;

	// Synchronise the seven active-low pins; idle level of each is high
	mpsc_sync #(
		.W(NIN)
	) u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.pin_in({thermal_alarm_n, lid_switch_n, sleep_button_n, wake_n,
			battery_low_n, reset_button_n, power_button_n}),
		.pin_out(pins_s)
	);

	// Qualified presses: power, reset, sleep, lid
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_press
			wire lvl = (gi == 0) ? pwr_s : (gi == 1) ? rstb_s : (gi == 2) ? slp_s : lid_s;
			mpsc_press #(
				.CNT_W(CNT_W),
				.HOLD(PRESS_CYC)
			) u_press (
				.core_clk(core_clk),
				.rst(rst),
				.level_n(lvl),
				.press(press[gi])
			);
		end
	endgenerate

	// Level inputs that are active high need their own synchronisers
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pg_meta_ff <= 1'b0;
			pg_ff <= 1'b0;
			heat_meta_ff <= 1'b0;
			heat_ff <= 1'b0;
			bat_d_ff <= 1'b1;
			wake_d_ff <= 1'b1;
			therm_d_ff <= 1'b1;
		end else begin
			pg_meta_ff <= carrier_power_good;
			pg_ff <= pg_meta_ff;
			heat_meta_ff <= cpu_overheat;
			heat_ff <= heat_meta_ff;
			bat_d_ff <= bat_s;
			wake_d_ff <= wake_s;
			therm_d_ff <= therm_s;
		end
	end

	function is_low_power;
		input [`MPSC_ST_W-1:0] st;
		begin
			is_low_power = (st == `MPSC_ST_S3) || (st == `MPSC_ST_S4) || (st == `MPSC_ST_S5);
		end
	endfunction

	function is_off;
		input [`MPSC_ST_W-1:0] st;
		begin
			is_off = (st == `MPSC_ST_S4) || (st == `MPSC_ST_S5);
		end
	endfunction

	// Events: edges into the asserted level
	always @* begin
		ev = {`MPSC_EV_W{1'b0}};
		ev[`MPSC_EV_PWR] = press[0];
		ev[`MPSC_EV_RST] = press[1];
		ev[`MPSC_EV_BAT] = bat_d_ff & ~bat_s;
		ev[`MPSC_EV_WAKE] = wake_d_ff & ~wake_s;
		ev[`MPSC_EV_SLP] = press[2];
		ev[`MPSC_EV_LID] = press[3];
		ev[`MPSC_EV_THERM] = therm_d_ff & ~therm_s;
		trip = heat_ff | ctrl_ff[`MPSC_CTL_TRIP];
	end

	// State sequencing
	always @* begin
		nxt_state = state_ff;
		nxt_target = target_ff;
		case (state_ff)
			`MPSC_ST_S5: begin
				if (press[0] && !trip)
					nxt_state = `MPSC_ST_UP;
			end
			`MPSC_ST_UP: begin
				if (pg_ff)
					nxt_state = `MPSC_ST_S0;
			end
			`MPSC_ST_S0: begin
				if (press[0] || ctrl_ff[`MPSC_CTL_OFF]) begin
					nxt_state = `MPSC_ST_NOTE;
					nxt_target = `MPSC_ST_S5;
				end else if (ctrl_ff[`MPSC_CTL_SLEEP_S4]) begin
					nxt_state = `MPSC_ST_NOTE;
					nxt_target = `MPSC_ST_S4;
				end else if (press[2] || press[3] || ctrl_ff[`MPSC_CTL_SLEEP_S3]) begin
					nxt_state = `MPSC_ST_NOTE;
					nxt_target = `MPSC_ST_S3;
				end
			end
			`MPSC_ST_NOTE: begin
				if (note_cnt_ff == NOTICE_CYC)
					nxt_state = target_ff;
			end
			`MPSC_ST_S3, `MPSC_ST_S4: begin
				if (press[0] || press[2] || press[3] || ev[`MPSC_EV_WAKE])
					nxt_state = `MPSC_ST_UP;
			end
			default: begin
				nxt_state = `MPSC_ST_S5;
			end
		endcase
		if (trip)
			nxt_state = `MPSC_ST_S5;
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_ff <= `MPSC_ST_S5;
			target_ff <= `MPSC_ST_S5;
			note_cnt_ff <= 8'h00;
			suspend_status_n <= 1'b0;
			suspend_to_ram_n <= 1'b0;
			soft_off_state_n <= 1'b0;
			thermal_trip_n <= 1'b1;
			module_reset_n <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			target_ff <= nxt_target;
			if (state_ff == `MPSC_ST_NOTE)
				note_cnt_ff <= note_cnt_ff + 8'h01;
			else
				note_cnt_ff <= 8'h00;
			suspend_status_n <= !(is_low_power(nxt_state) || nxt_state == `MPSC_ST_NOTE);
			suspend_to_ram_n <= !is_low_power(nxt_state);
			soft_off_state_n <= !is_off(nxt_state);
			thermal_trip_n <= !trip;
			module_reset_n <= !(press[1] || nxt_state != `MPSC_ST_S0);
		end
	end

	// Register file; set wins over write-one-to-clear
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			status_ff <= {`MPSC_EV_W{1'b0}};
			mask_ff <= {`MPSC_EV_W{1'b0}};
			ctrl_ff <= {`MPSC_CTL_W{1'b0}};
			reg_rdata <= `MPSC_ZERO32;
			irq <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == `MPSC_REG_STATUS)
				status_ff <= (status_ff & ~reg_wdata[`MPSC_EV_W-1:0]) | ev;
			else
				status_ff <= status_ff | ev;
			if (reg_wr && reg_addr == `MPSC_REG_MASK)
				mask_ff <= reg_wdata[`MPSC_EV_W-1:0];
			if (reg_wr && reg_addr == `MPSC_REG_CTRL)
				ctrl_ff <= reg_wdata[`MPSC_CTL_W-1:0];
			else
				ctrl_ff <= ctrl_ff & {1'b1, 3'b000};
			reg_rdata <= `MPSC_ZERO32;
			if (reg_rd) begin
				case (reg_addr)
					`MPSC_REG_STATUS: reg_rdata <= {25'h000_0000, status_ff};
					`MPSC_REG_MASK: reg_rdata <= {25'h000_0000, mask_ff};
					`MPSC_REG_CTRL: reg_rdata <= {28'h000_0000, ctrl_ff};
					`MPSC_REG_STATE: reg_rdata <= {24'h00_0000, pg_ff, heat_ff, state_ff};
					default: reg_rdata <= `MPSC_ZERO32;
				endcase
			end
			irq <= |(status_ff & mask_ff);
		end
	end
endmodule

// file: rtl/mpsc_map.vh
/*
 Constants for the module power-state controller: register offsets, field positions,
 reset values, state codes and timing figures.
 Assumes a single always-on standby clock at 125 MHz.
*/
// Overview of operation
// - Power-up proceeds only while the carrier power-good input is high.
// - A power-button request is taken on the falling edge of the button, held 16 ms.
// - The reset button held low for 16 ms resets the module.
// - A low battery-low input is reported as a power-management event.
// - A low external wake input is a wake event that starts leaving the S3 or S4 state.
// - Suspend status goes low shortly before a low-power state is entered.
// - Suspend-to-RAM output is low in the S3, S4 and S5 states.
// - Soft-off output is low in S4 and S5 and high in every other state.
// - The sleep button falling edge requests sleep entry or wake, held 16 ms.
// - The lid switch low pulse of 16 ms requests sleep entry or wake.
// - On overheating the thermal-trip output goes low and the system goes straight to S5.
// - A low thermal alarm input is flagged as an over-temperature event.
`ifndef MPSC_MAP_VH
`define MPSC_MAP_VH

`define MPSC_CLK_MHZ 125
`define MPSC_PRESS_MS 16
// Press hold in standby clocks: 16 ms at 125 MHz, sized to the counter
`define MPSC_PRESS_CYC 22'h1e_8480
`define MPSC_NOTICE_CYC 8'h10
`define MPSC_CNT_W 22

// Register offsets
`define MPSC_REG_STATUS 4'h0
`define MPSC_REG_MASK 4'h4
`define MPSC_REG_CTRL 4'h8
`define MPSC_REG_STATE 4'hc

// Event bits of status and mask
`define MPSC_EV_W 7
`define MPSC_EV_PWR 0
`define MPSC_EV_RST 1
`define MPSC_EV_BAT 2
`define MPSC_EV_WAKE 3
`define MPSC_EV_SLP 4
`define MPSC_EV_LID 5
`define MPSC_EV_THERM 6

// Control bits
`define MPSC_CTL_SLEEP_S3 0
`define MPSC_CTL_SLEEP_S4 1
`define MPSC_CTL_OFF 2
`define MPSC_CTL_TRIP 3
`define MPSC_CTL_W 4

// Power states, one-hot
`define MPSC_ST_W 6
`define MPSC_ST_S5 6'h01
`define MPSC_ST_UP 6'h02
`define MPSC_ST_S0 6'h04
`define MPSC_ST_NOTE 6'h08
`define MPSC_ST_S3 6'h10
`define MPSC_ST_S4 6'h20

`define MPSC_ZERO32 32'h0000_0000

`endif

// file: rtl/mpsc_sync.v
/*
 Two-flop synchroniser bank for the button and event pins.
 Assumes inputs idle high and reset is asynchronous active high.
*/
module mpsc_sync #(
	parameter W = 8
) (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Pins and synchronised levels
	input wire [W-1:0] pin_in,
	output wire [W-1:0] pin_out
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_ff <= {W{1'b1}};
			sync_ff <= {W{1'b1}};
		end else begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
		end
	end

	assign pin_out = sync_ff;
endmodule

// file: rtl/mpsc_press.v
/*
 Press qualifier: a low level must stand for a full count before a one-cycle
 press pulse is given; the pulse marks the falling edge once it is qualified.
 Assumes a synchronised active-low input.
*/
module mpsc_press #(
	parameter CNT_W = 22,
	parameter [CNT_W-1:0] HOLD = 22'h1e_8480
) (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Synchronised input and qualified press
	input wire level_n,
	output wire press
);
	reg [CNT_W-1:0] cnt_ff;
	reg done_ff;
	reg press_ff;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= {CNT_W{1'b0}};
			done_ff <= 1'b0;
			press_ff <= 1'b0;
		end else begin
			press_ff <= 1'b0;
			if (level_n) begin
				cnt_ff <= {CNT_W{1'b0}};
				done_ff <= 1'b0;
			end else if (!done_ff) begin
				if (cnt_ff == HOLD - 1'b1) begin
					done_ff <= 1'b1;
					press_ff <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff + 1'b1;
				end
			end
		end
	end

	assign press = press_ff;
endmodule

// file: test/mpsc_top_asserts.sv
/*
 Pin assertions for the power-state controller.
 Assumes one clock and an active-high asynchronous reset.
*/
module mpsc_top_asserts (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Inputs
	input wire carrier_power_good,
	input wire wake_n,
	input wire cpu_overheat,
	// Outputs
	input wire suspend_status_n,
	input wire suspend_to_ram_n,
	input wire soft_off_state_n,
	input wire thermal_trip_n,
	input wire module_reset_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dclk @(posedge core_clk);
	endclocking
	default disable iff (rst);
	sequence s_note;
		$fell(suspend_status_n) && suspend_to_ram_n && thermal_trip_n;
	endsequence
	sequence s_pg_low;
		!carrier_power_good [*6];
	endsequence
	property p_notice;
		s_note |-> suspend_to_ram_n [*4];
	endproperty
	a_notice: assert property (p_notice) else $error("no suspend notice");
	property p_ram;
		!suspend_to_ram_n |-> !suspend_status_n;
	endproperty
	a_ram: assert property (p_ram) else $error("ram off without status");
	property p_off;
		!soft_off_state_n |-> !suspend_to_ram_n;
	endproperty
	a_off: assert property (p_off) else $error("soft off without ram off");
	property p_order;
		$fell(suspend_to_ram_n) && thermal_trip_n |-> !$past(suspend_status_n);
	endproperty
	a_order: assert property (p_order) else $error("status came late");
	property p_trip;
		cpu_overheat |-> ##[1:5] (!thermal_trip_n && !soft_off_state_n);
	endproperty
	a_trip: assert property (p_trip) else $error("overheat not tripped");
	property p_trip_off;
		$fell(thermal_trip_n) |-> ##[0:2] !soft_off_state_n;
	endproperty
	a_trip_off: assert property (p_trip_off) else $error("trip not soft off");
	property p_pg;
		s_pg_low |=> !$rose(module_reset_n);
	endproperty
	a_pg: assert property (p_pg) else $error("run without power good");
	property p_wake;
		$fell(wake_n) && !suspend_to_ram_n && soft_off_state_n |-> ##[2:8] suspend_to_ram_n;
	endproperty
	a_wake: assert property (p_wake) else $error("wake ignored");
endmodule

bind mpsc_top mpsc_top_asserts i_chk (.core_clk(core_clk), .rst(rst),
	.carrier_power_good(carrier_power_good), .wake_n(wake_n), .cpu_overheat(cpu_overheat),
	.suspend_status_n(suspend_status_n), .suspend_to_ram_n(suspend_to_ram_n),
	.soft_off_state_n(soft_off_state_n), .thermal_trip_n(thermal_trip_n),
	.module_reset_n(module_reset_n));

// file: test/mpsc_carrier.sv
/*
 Carrier model: buttons with pull-ups, power good once the rails settle.
 Assumes press is called just after a clock edge.
*/
module mpsc_carrier (
	// Clock and rails
	input logic core_clk,
	input logic rails_on,
	// Carrier pins
	output logic [3:0] btn_n,
	output logic carrier_power_good
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] rdy_ff = 4'h0;
	initial btn_n = 4'hf;
	always @(posedge core_clk) rdy_ff <= {rdy_ff[2:0], rails_on};
	assign carrier_power_good = rdy_ff[3] & rails_on;
	// Release returns the pin to its pull-up level
	task press(input int idx, input int len);
		btn_n[idx] <= 1'b0;
		repeat (len) @(posedge core_clk);
		btn_n[idx] <= 1'b1;
	endtask
endmodule

// file: test/module_power_state_control_tb.sv
/*
 Self-checking bench for the power-state controller.
 Assumes the carrier model drives the buttons and power good.
*/
module module_power_state_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PRESS = 8;
	logic core_clk = 0, rst = 1, rails_on = 0, cpu_overheat = 0;
	logic reg_wr = 0, reg_rd = 0, rd_d = 0, pg;
	logic [2:0] ev_n = 3'h7;
	logic [3:0] reg_addr = 4'h0, btn_n;
	logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, q[$];
	wire [5:0] pins;
	int err_total = 0, check_count = 0;
	int ebit[3] = '{2, 3, 6};
	initial forever #4 core_clk = ~core_clk;
	mpsc_carrier i_carrier (.core_clk(core_clk), .rails_on(rails_on), .btn_n(btn_n),
		.carrier_power_good(pg));
	mpsc_top #(.PRESS_CYC(22'h8), .NOTICE_CYC(8'h4)) i_dut (.core_clk(core_clk), .rst(rst),
		.carrier_power_good(pg), .power_button_n(btn_n[0]), .reset_button_n(btn_n[1]),
		.battery_low_n(ev_n[0]), .wake_n(ev_n[1]), .sleep_button_n(btn_n[2]),
		.lid_switch_n(btn_n[3]), .thermal_alarm_n(ev_n[2]), .cpu_overheat(cpu_overheat),
		.suspend_status_n(pins[0]), .suspend_to_ram_n(pins[1]), .soft_off_state_n(pins[2]),
		.thermal_trip_n(pins[3]), .module_reset_n(pins[4]), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.irq(pins[5]));
	task final_report;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Read data stand only in the cycle after the strobe
	always @(posedge core_clk) begin
		rd_d <= reg_rd;
		if (rd_d)
			chk("rdata", q.pop_front(), reg_rdata);
	end
	task wr(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		// Let an edge pass so a following write never reassigns the strobe
		@(posedge core_clk);
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e);
		q.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
	endtask
	task pin(input logic [3:0] e);
		chk("pins", {28'h000_0000, e}, {28'h000_0000, pins[3:0]});
	endtask
	task wait_for(input int i, input logic v);
		int n;
		n = 0;
		while (pins[i] !== v && n < 200) begin
			@(posedge core_clk);
			n++;
		end
		if (n == 200) begin
			err_total++;
			final_report();
		end
		@(posedge core_clk);
	endtask
	task ev(input int i);
		ev_n[i] <= 1'b0;
		repeat (4) @(posedge core_clk);
		ev_n[i] <= 1'b1;
		repeat (4) @(posedge core_clk);
	endtask
	initial begin
		void'($urandom(12));
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		pin(4'b1000);
		rd(4'hc, 32'h0000_0001);
		rd(4'h2, 32'h0000_0000);
		i_carrier.press(0, 1 + $urandom % 5);
		repeat (12) @(posedge core_clk);
		rd(4'hc, 32'h0000_0001);
		i_carrier.press(0, PRESS + 2 + $urandom % 4);
		wait_for(1, 1'b1);
		rd(4'hc, 32'h0000_0002);
		rails_on <= 1'b1;
		wait_for(4, 1'b1);
		pin(4'b1111);
		rd(4'hc, 32'h0000_0084);
		wr(4'h0, 32'h0000_007f);
		$display("power-up test ended");
		foreach (ebit[k]) begin
			ev(k);
			rd(4'h0, 32'h0000_0001 << ebit[k]);
			chk("irq", 32'h0000_0000, {31'h0, pins[5]});
			wr(4'h4, 32'h0000_007f);
			repeat (2) @(posedge core_clk);
			chk("irq", 32'h0000_0001, {31'h0, pins[5]});
			wr(4'h0, 32'h0000_0001 << ebit[k]);
			wr(4'h4, 32'h0000_0000);
			repeat (2) @(posedge core_clk);
			rd(4'h0, 32'h0000_0000);
		end
		$display("event test ended");
		wr(4'h8, 32'h0000_0001);
		wait_for(1, 1'b0);
		pin(4'b1100);
		ev(1);
		wait_for(4, 1'b1);
		i_carrier.press(2, PRESS + 4);
		wait_for(1, 1'b0);
		i_carrier.press(3, PRESS + 4);
		wait_for(4, 1'b1);
		i_carrier.press(1, PRESS + 4);
		wait_for(4, 1'b0);
		wait_for(4, 1'b1);
		rd(4'h0, 32'h0000_003a);
		$display("sleep test ended");
		cpu_overheat <= 1'b1;
		wait_for(2, 1'b0);
		pin(4'b0000);
		rd(4'hc, 32'h0000_00c1);
		cpu_overheat <= 1'b0;
		wait_for(3, 1'b1);
		wr(4'h8, 32'h0000_0008);
		wait_for(3, 1'b0);
		wr(4'h8, 32'h0000_0000);
		wait_for(3, 1'b1);
		i_carrier.press(0, PRESS + 4);
		wait_for(4, 1'b1);
		i_carrier.press(0, PRESS + 4);
		wait_for(2, 1'b0);
		pin(4'b1000);
		$display("trip test ended");
		final_report();
	end
endmodule
